// ===== rtl/pwm_compare_unit.sv
// Per-channel compare shadow, loading modes and match events
`default_nettype none
`include "pwm_tb_defs.svh"
module pwm_compare_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] cmp_value,
  input wire logic [15:0] cmp_new,
  input wire logic cmp_wr,
  input wire logic imm_en,
  input wire logic ctr_en,
  input wire logic updn,
  input wire logic period_end,
  input wire logic center_pt,
  input wire logic tick,
  input wire logic [15:0] cnt_next,
  input wire logic dir_next,
  output logic [15:0] shadow,
  output logic up_evt,
  output logic dn_evt
);
  // ==================================================================
  // Shadow loading and match
  logic [15:0] shadow_reg, shadow_next;
  logic up_evt_reg, up_evt_next;
  logic dn_evt_reg, dn_evt_next;
  logic hit;

  // Immediate wins; center only in up-down; period loading is the fallback
  always_comb
  begin
    shadow_next = shadow_reg;
    if (imm_en)
    begin
      if (cmp_wr)
        shadow_next = cmp_new;
    end
    else if (ctr_en && updn)
    begin
      if (center_pt)
        shadow_next = cmp_value;
    end
    else if (period_end)
      shadow_next = cmp_value;
    // Matching uses the shadow only, never the programmable value
    hit = tick && (cnt_next == shadow_reg);
    up_evt_next = hit && dir_next;
    dn_evt_next = hit && !dir_next;
  end

  // Shadow and events start at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow_reg <= 16'h0000;
      up_evt_reg <= 1'b0;
      dn_evt_reg <= 1'b0;
    end
    else
    begin
      shadow_reg <= shadow_next;
      up_evt_reg <= up_evt_next;
      dn_evt_reg <= dn_evt_next;
    end
  end

  assign shadow = shadow_reg;
  assign up_evt = up_evt_reg;
  assign dn_evt = dn_evt_reg;

  // ==================================================================
  // Checks
  a_cmp_match: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && cnt_next == shadow_reg |=> (up_evt_reg || dn_evt_reg))
    else $error("compare match lost");
  a_imm_load: assert property (@(posedge aclk) disable iff (!aresetn)
    imm_en && cmp_wr |=> shadow_reg == $past(cmp_new))
    else $error("immediate compare load missed");
  a_center_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !imm_en && ctr_en && updn && !center_pt |=> $stable(shadow_reg))
    else $error("center-mode shadow moved off center");
  c_two_events: cover property (@(posedge aclk) disable iff (!aresetn)
    up_evt_reg ##[1:300] dn_evt_reg);
endmodule
`default_nettype wire

// ===== rtl/pwm_tb_defs.svh
// Offsets, field positions, reset values and widths of the PWM time base
`ifndef PWM_TB_DEFS_SVH
`define PWM_TB_DEFS_SVH
// ==================================================================
// Register byte offsets (per-pair and per-channel blocks step by 4)
`define OFS_LOAD_CTL 8'h00
`define OFS_TYPE_CTL 8'h04
`define OFS_RUN_CTL 8'h08
`define OFS_PRESCALE 8'h10
`define OFS_PERIOD 8'h20
`define OFS_COUNT 8'h30
`define OFS_COMPARE 8'h40
`define OFS_PSHADOW 8'h60
`define OFS_CSHADOW 8'h70
// ==================================================================
// Sizes and field positions
`define ADDR_W 8
`define NUM_CH 6
`define NUM_PAIR 3
`define PSC_W 12
`define CNT_W 16
`define TYPE_CTL_W 12
`define CENTER_LSB 0
`define IMMED_LSB 16
`define DIR_BIT 16
`define LOAD_CTL_MASK 32'h003F003F
// ==================================================================
// Counter type codes in the type field (two bits per pair, stride 4)
`define TYPE_UP 2'h0
`define TYPE_DOWN 2'h1
`define TYPE_UPDN 2'h2
// ==================================================================
// Reset values and bus responses
`define RST_ZERO32 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/pwm_tb_pkg.sv
// Types shared by the PWM time base files
`default_nettype none
package pwm_tb_pkg;
  // One-hot counter type, decoded from the type field
  typedef enum logic [2:0] {
    CT_UP = 3'h1,
    CT_DOWN = 3'h2,
    CT_UPDN = 3'h4
  } cnt_type_t;
endpackage
`default_nettype wire

// ===== rtl/pwm_timebase.sv
// PWM time base: prescalers, counters, period shadows, AXI4-Lite registers
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
`include "pwm_tb_defs.svh"
// Functional notes
// - Counter steps once per prescale plus one
// - Up type counts zero to period shadow
// - Zero and period events in up/down
// - Up period lasts period plus one
// - Down type counts period to zero
// - Up-down counts up then back down
// - Up-down: zero and center events
// - Direction flag high up, low down
// - Count field reads live counter value
// - Compare equality with counter gives event
// - Up-down gives up and down matches
// - Counting and compare use shadow copies
// - Period loading is lowest-priority default
// - Period loading only at period end
// - Immediate enable loads shadow on write
// - Immediate loading overrides other modes
// - Larger new period: count up to it
// - Smaller new period: wrap through maximum
// - Center mode loads compare at mid-period
module pwm_timebase (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [2:0] zero_evt,
  output logic [2:0] period_evt,
  output logic [2:0] center_evt,
  output logic [5:0] cmp_up_evt,
  output logic [5:0] cmp_dn_evt
);
  // ==================================================================
  // Helpers
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // Reserved code 3 falls back to up counting
  function automatic pwm_tb_pkg::cnt_type_t type_of(input logic [1:0] c);
    pwm_tb_pkg::cnt_type_t t;
    unique case (c)
      `TYPE_DOWN: t = pwm_tb_pkg::CT_DOWN;
      `TYPE_UPDN: t = pwm_tb_pkg::CT_UPDN;
      default: t = pwm_tb_pkg::CT_UP;
    endcase
    return t;
  endfunction

  // ==================================================================
  // State
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] load_ctl_reg, load_ctl_next;
  logic [`TYPE_CTL_W-1:0] type_ctl_reg, type_ctl_next;
  logic [2:0] run_reg, run_next;
  logic [`PSC_W-1:0] presc_reg [`NUM_PAIR];
  logic [`PSC_W-1:0] presc_next [`NUM_PAIR];
  logic [`CNT_W-1:0] period_reg [`NUM_PAIR];
  logic [`CNT_W-1:0] period_next [`NUM_PAIR];
  logic [`CNT_W-1:0] cmp_reg [`NUM_CH];
  logic [`CNT_W-1:0] cmp_next [`NUM_CH];
  logic [`PSC_W-1:0] psc_reg [`NUM_PAIR];
  logic [`PSC_W-1:0] psc_next [`NUM_PAIR];
  logic [`CNT_W-1:0] cnt_reg [`NUM_PAIR];
  logic [`CNT_W-1:0] cnt_next [`NUM_PAIR];
  logic [`CNT_W-1:0] period_shadow_reg [`NUM_PAIR];
  logic [`CNT_W-1:0] period_shadow_next [`NUM_PAIR];
  logic [2:0] dir_reg, dir_next;
  logic [2:0] zero_reg, zero_next, per_reg, per_next, ctr_reg, ctr_next;
  logic wr_go, wr_ok, ar_take, rd_ok;
  logic [31:0] rd_word;
  logic [2:0] imm_wr, tick, pend, cpt, updn;
  logic [5:0] cmp_wr, up_w, dn_w;
  logic [`CNT_W-1:0] cshadow [`NUM_CH];
  pwm_tb_pkg::cnt_type_t typ [`NUM_PAIR];

  // ==================================================================
  // AXI4-Lite handshakes: address and data latched in either order,
  // one write and one read outstanding
  always_comb
  begin
    wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    ar_take = arvalid && arready_reg;
    aw_full_next = (aw_full_reg && !wr_go) || (awvalid && awready_reg);
    w_full_next = (w_full_reg && !wr_go) || (wvalid && wready_reg);
    aw_addr_next = (awvalid && awready_reg) ? awaddr : aw_addr_reg;
    w_data_next = (wvalid && wready_reg) ? wdata : w_data_reg;
    w_strb_next = (wvalid && wready_reg) ? wstrb : w_strb_reg;
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
    bvalid_next = wr_go || (bvalid_reg && !bready);
    bresp_next = wr_go ? (wr_ok ? `RESP_OKAY : `RESP_SLVERR) : bresp_reg;
    rvalid_next = ar_take || (rvalid_reg && !rready);
    arready_next = !rvalid_next;
    rdata_next = ar_take ? rd_word : rdata_reg;
    rresp_next = ar_take ? (rd_ok ? `RESP_OKAY : `RESP_SLVERR) : rresp_reg;
  end

  // Bus registers; ready outputs rise on the first edge after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `RST_ZERO32;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `RST_ZERO32;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ==================================================================
  // Register writes; software only ever touches programmable values
  always_comb
  begin
    load_ctl_next = load_ctl_reg;
    type_ctl_next = type_ctl_reg;
    run_next = run_reg;
    presc_next = presc_reg;
    period_next = period_reg;
    cmp_next = cmp_reg;
    imm_wr = 3'h0;
    cmp_wr = 6'h00;
    wr_ok = 1'b0;
    if (wr_go)
    begin
      if (aw_addr_reg == `OFS_LOAD_CTL)
      begin
        load_ctl_next = merge(load_ctl_reg, w_data_reg, w_strb_reg) & `LOAD_CTL_MASK;
        wr_ok = 1'b1;
      end
      if (aw_addr_reg == `OFS_TYPE_CTL)
      begin
        type_ctl_next = `TYPE_CTL_W'(merge({20'h00000, type_ctl_reg}, w_data_reg,
          w_strb_reg));
        wr_ok = 1'b1;
      end
      if (aw_addr_reg == `OFS_RUN_CTL)
      begin
        run_next = 3'(merge({29'h0, run_reg}, w_data_reg, w_strb_reg));
        wr_ok = 1'b1;
      end
      for (int k = 0; k < `NUM_PAIR; k++)
      begin
        if (aw_addr_reg == `OFS_PRESCALE + 8'(4 * k))
        begin
          presc_next[k] = `PSC_W'(merge({20'h00000, presc_reg[k]}, w_data_reg,
            w_strb_reg));
          wr_ok = 1'b1;
        end
        if (aw_addr_reg == `OFS_PERIOD + 8'(4 * k))
        begin
          period_next[k] = `CNT_W'(merge({16'h0000, period_reg[k]}, w_data_reg,
            w_strb_reg));
          imm_wr[k] = load_ctl_reg[`IMMED_LSB + 2 * k];
          wr_ok = 1'b1;
        end
      end
      for (int c = 0; c < `NUM_CH; c++)
      begin
        if (aw_addr_reg == `OFS_COMPARE + 8'(4 * c))
        begin
          cmp_next[c] = `CNT_W'(merge({16'h0000, cmp_reg[c]}, w_data_reg,
            w_strb_reg));
          cmp_wr[c] = 1'b1;
          wr_ok = 1'b1;
        end
      end
    end
  end

  // Controls clear at reset so period loading is in effect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_ctl_reg <= `RST_ZERO32;
      type_ctl_reg <= 12'h000;
      run_reg <= 3'h0;
      for (int k = 0; k < `NUM_PAIR; k++)
      begin
        presc_reg[k] <= 12'h000;
        period_reg[k] <= 16'h0000;
      end
      for (int c = 0; c < `NUM_CH; c++)
        cmp_reg[c] <= 16'h0000;
    end
    else
    begin
      load_ctl_reg <= load_ctl_next;
      type_ctl_reg <= type_ctl_next;
      run_reg <= run_next;
      presc_reg <= presc_next;
      period_reg <= period_next;
      cmp_reg <= cmp_next;
    end
  end

  // ==================================================================
  // Read decode, captured into rdata on the address handshake
  always_comb
  begin
    rd_word = `RST_ZERO32;
    rd_ok = 1'b1;
    if (araddr == `OFS_LOAD_CTL)
      rd_word = load_ctl_reg;
    else if (araddr == `OFS_TYPE_CTL)
      rd_word = {20'h00000, type_ctl_reg};
    else if (araddr == `OFS_RUN_CTL)
      rd_word = {29'h0, run_reg};
    else
      rd_ok = 1'b0;
    for (int k = 0; k < `NUM_PAIR; k++)
    begin
      if (araddr == `OFS_PRESCALE + 8'(4 * k))
      begin
        rd_word = {20'h00000, presc_reg[k]};
        rd_ok = 1'b1;
      end
      if (araddr == `OFS_PERIOD + 8'(4 * k))
      begin
        rd_word = {16'h0000, period_reg[k]};
        rd_ok = 1'b1;
      end
      if (araddr == `OFS_COUNT + 8'(4 * k))
      begin
        rd_word = {15'h0000, dir_reg[k], cnt_reg[k]};
        rd_ok = 1'b1;
      end
      if (araddr == `OFS_PSHADOW + 8'(4 * k))
      begin
        rd_word = {16'h0000, period_shadow_reg[k]};
        rd_ok = 1'b1;
      end
    end
    for (int c = 0; c < `NUM_CH; c++)
    begin
      if (araddr == `OFS_COMPARE + 8'(4 * c))
      begin
        rd_word = {16'h0000, cmp_reg[c]};
        rd_ok = 1'b1;
      end
      if (araddr == `OFS_CSHADOW + 8'(4 * c))
      begin
        rd_word = {16'h0000, cshadow[c]};
        rd_ok = 1'b1;
      end
    end
  end

  // ==================================================================
  // Prescalers and counters, one per channel pair
  always_comb
  begin
    psc_next = psc_reg;
    cnt_next = cnt_reg;
    period_shadow_next = period_shadow_reg;
    dir_next = dir_reg;
    tick = 3'h0;
    pend = 3'h0;
    cpt = 3'h0;
    updn = 3'h0;
    zero_next = 3'h0;
    per_next = 3'h0;
    ctr_next = 3'h0;
    for (int k = 0; k < `NUM_PAIR; k++)
    begin
      typ[k] = type_of(type_ctl_reg[4 * k +: 2]);
      updn[k] = (typ[k] == pwm_tb_pkg::CT_UPDN);
      // A stopped pair holds its count and restarts a full prescale
      if (!run_reg[k])
        psc_next[k] = 12'h000;
      else if (psc_reg[k] == presc_reg[k])
      begin
        psc_next[k] = 12'h000;
        tick[k] = 1'b1;
      end
      else
        psc_next[k] = psc_reg[k] + 12'h001;
      if (tick[k])
      begin
        unique case (typ[k])
          pwm_tb_pkg::CT_UP:
          begin
            dir_next[k] = 1'b1;
            // Plain +1 wraps through FFFF when the shadow fell below
            if (cnt_reg[k] == period_shadow_reg[k])
            begin
              pend[k] = 1'b1;
              cnt_next[k] = 16'h0000;
            end
            else
              cnt_next[k] = cnt_reg[k] + 16'h0001;
          end
          pwm_tb_pkg::CT_DOWN:
          begin
            dir_next[k] = 1'b0;
            if (cnt_reg[k] == 16'h0000)
            begin
              pend[k] = 1'b1;
              cnt_next[k] = load_ctl_reg[`IMMED_LSB + 2 * k] ? period_shadow_reg[k]
                : period_reg[k];
            end
            else
              cnt_next[k] = cnt_reg[k] - 16'h0001;
          end
          pwm_tb_pkg::CT_UPDN:
          begin
            if (dir_reg[k])
            begin
              if (cnt_reg[k] == period_shadow_reg[k])
              begin
                dir_next[k] = 1'b0;
                cnt_next[k] = (cnt_reg[k] == 16'h0000) ? 16'h0000
                  : cnt_reg[k] - 16'h0001;
              end
              else
                cnt_next[k] = cnt_reg[k] + 16'h0001;
            end
            else if (cnt_reg[k] == 16'h0000)
            begin
              pend[k] = 1'b1;
              dir_next[k] = 1'b1;
              // A zero shadow parks the counter at zero instead of running away
              cnt_next[k] = (period_shadow_reg[k] == 16'h0000) ? 16'h0000 : 16'h0001;
            end
            else
              cnt_next[k] = cnt_reg[k] - 16'h0001;
          end
        endcase
      end
      // Immediate writes bypass period loading altogether
      if (load_ctl_reg[`IMMED_LSB + 2 * k])
      begin
        if (imm_wr[k])
          period_shadow_next[k] = period_next[k];
      end
      else if (pend[k])
        period_shadow_next[k] = period_reg[k];
      cpt[k] = tick[k] && updn[k] && dir_next[k] && cnt_next[k] == period_shadow_reg[k];
      zero_next[k] = tick[k] && cnt_next[k] == 16'h0000;
      per_next[k] = tick[k] && !updn[k] && cnt_next[k] == period_shadow_next[k];
      ctr_next[k] = cpt[k];
    end
  end

  // Counter state clears at reset; direction starts as up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int k = 0; k < `NUM_PAIR; k++)
      begin
        psc_reg[k] <= 12'h000;
        cnt_reg[k] <= 16'h0000;
        period_shadow_reg[k] <= 16'h0000;
      end
      dir_reg <= 3'h7;
      zero_reg <= 3'h0;
      per_reg <= 3'h0;
      ctr_reg <= 3'h0;
    end
    else
    begin
      psc_reg <= psc_next;
      cnt_reg <= cnt_next;
      period_shadow_reg <= period_shadow_next;
      dir_reg <= dir_next;
      zero_reg <= zero_next;
      per_reg <= per_next;
      ctr_reg <= ctr_next;
    end
  end

  // ==================================================================
  // Compare channels; pair p serves channels 2p and 2p+1
  for (genvar c = 0; c < `NUM_CH; c++)
  begin : g_ch
    pwm_compare_unit u_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .cmp_value(cmp_reg[c]),
      .cmp_new(cmp_next[c]),
      .cmp_wr(cmp_wr[c]),
      .imm_en(load_ctl_reg[`IMMED_LSB + c]),
      .ctr_en(load_ctl_reg[`CENTER_LSB + c]),
      .updn(updn[c / 2]),
      .period_end(pend[c / 2]),
      .center_pt(cpt[c / 2]),
      .tick(tick[c / 2]),
      .cnt_next(cnt_next[c / 2]),
      .dir_next(dir_next[c / 2]),
      .shadow(cshadow[c]),
      .up_evt(up_w[c]),
      .dn_evt(dn_w[c])
    );
  end

  // Outputs, all from flip-flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign zero_evt = zero_reg;
  assign period_evt = per_reg;
  assign center_evt = ctr_reg;
  assign cmp_up_evt = up_w;
  assign cmp_dn_evt = dn_w;

  // ==================================================================
  // Checks on pair 0, down type on pair 1, up-down on pair 2;
  // gap counts cycles since the last tick of pair 0
  logic [`PSC_W-1:0] gap_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_reg[0] || tick[0])
      gap_reg <= 12'h000;
    else
      gap_reg <= gap_reg + 12'h001;
  end

  a_psc_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && $stable(presc_reg[0]) && $past(run_reg[0]) |-> gap_reg == presc_reg[0])
    else $error("prescaler tick spacing wrong");
  a_up_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && typ[0] == pwm_tb_pkg::CT_UP && cnt_reg[0] == period_shadow_reg[0]
    |=> cnt_reg[0] == 16'h0000)
    else $error("up counter did not wrap at period");
  a_down_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[1] && typ[1] == pwm_tb_pkg::CT_DOWN && cnt_reg[1] == 16'h0000
    && !load_ctl_reg[`IMMED_LSB + 2] |=> cnt_reg[1] == period_shadow_reg[1])
    else $error("down counter did not reload period");
  a_updn_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[2] && updn[2] && dir_reg[2] && cnt_reg[2] == period_shadow_reg[2]
    && period_shadow_reg[2] != 16'h0000
    |=> !dir_reg[2] && cnt_reg[2] == $past(cnt_reg[2]) - 16'h0001)
    else $error("up-down counter did not turn at period");
  a_zero_event: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && cnt_next[0] == 16'h0000 |=> zero_evt[0] ##1 (!zero_evt[0] || $past(tick[0])))
    else $error("zero event missing");
  a_dir_up: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && typ[0] == pwm_tb_pkg::CT_UP |=> dir_reg[0])
    else $error("direction flag low in up type");
  a_count_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && araddr == `OFS_COUNT |=> rvalid && rdata[15:0] == $past(cnt_reg[0]))
    else $error("count read mismatch");
  a_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !load_ctl_reg[`IMMED_LSB + 2] && !pend[1] |=> $stable(period_shadow_reg[1]))
    else $error("period shadow changed mid-period");
  a_imm_period: assert property (@(posedge aclk) disable iff (!aresetn)
    imm_wr[0] |=> period_shadow_reg[0] == period_reg[0])
    else $error("immediate period load missed");
  c_up_period: cover property (@(posedge aclk) disable iff (!aresetn)
    period_evt[0] ##[1:300] zero_evt[0]);
  c_center: cover property (@(posedge aclk) disable iff (!aresetn) center_evt[2]);
  c_write_resp: cover property (@(posedge aclk) disable iff (!aresetn)
    bvalid && bready ##[1:8] rvalid && rready);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the PWM time base: bus access, counting, loading modes
`default_nettype none
`include "pwm_tb_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] zero_evt, period_evt, center_evt;
  wire logic [5:0] cmp_up_evt, cmp_dn_evt;
  wire logic [20:0] evts;
  int n_fail = 0, check_count = 0, cyc = 0, p, per, c;
  // ==================================================================
  // Device under test and flat event vector
  pwm_timebase uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .zero_evt(zero_evt), .period_evt(period_evt), .center_evt(center_evt),
    .cmp_up_evt(cmp_up_evt), .cmp_dn_evt(cmp_dn_evt));
  assign evts = {cmp_dn_evt, cmp_up_evt, center_evt, period_evt, zero_evt};
  always #2 aclk = ~aclk;
  // ==================================================================
  // Verdict and hang guard
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short; the whole run needs only about a thousand cycles at most
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ==================================================================
  // Bus master: ready for answers is held high, so only valids move
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", ed, rdata);
  endtask
  // Bus-clock cycles for a number of counter steps at the drawn prescale
  function automatic int cycles_of(input int steps);
    return steps * (p + 1);
  endfunction
  // Cycles between two successive pulses of one event line
  task automatic gap(input int idx, input int exp);
    int n;
    n = 0;
    do @(posedge aclk); while (evts[idx] !== 1'b1);
    do
    begin
      @(posedge aclk);
      n++;
    end while (evts[idx] !== 1'b1);
    chk("event gap", 32'(exp), 32'(n));
  endtask
  // ==================================================================
  // Main sequence: pair 0 up, pair 1 down, pair 2 up-down
  initial
  begin
    void'($urandom(32'hC51139C6));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    p = $urandom_range(3, 0);
    per = $urandom_range(9, 3);
    c = $urandom_range(per - 1, 1);
    rd(`OFS_COUNT, 32'h00010000, `RESP_OKAY);
    rd(`OFS_LOAD_CTL, `RST_ZERO32, `RESP_OKAY);
    rd(8'hFC, `RST_ZERO32, `RESP_SLVERR);
    wr(`OFS_COUNT, 32'h00000005, `RESP_SLVERR);
    rd(`OFS_COUNT, 32'h00010000, `RESP_OKAY);
    // Immediate on ch0 and ch4, center load on ch5
    wr(`OFS_LOAD_CTL, 32'h00110020, `RESP_OKAY);
    wr(`OFS_TYPE_CTL, 32'h00000210, `RESP_OKAY);
    for (int k = 0; k < 3; k++)
    begin
      wr(`OFS_PRESCALE + 8'(4 * k), 32'(p), `RESP_OKAY);
      wr(`OFS_PERIOD + 8'(4 * k), 32'(per), `RESP_OKAY);
    end
    rd(`OFS_PSHADOW + 8'h04, `RST_ZERO32, `RESP_OKAY);
    rd(`OFS_PSHADOW, 32'(per), `RESP_OKAY);
    rd(`OFS_PSHADOW + 8'h08, 32'(per), `RESP_OKAY);
    wr(`OFS_COMPARE, 32'(c), `RESP_OKAY);
    rd(`OFS_CSHADOW, 32'(c), `RESP_OKAY);
    wr(`OFS_COMPARE + 8'h04, 32'(c), `RESP_OKAY);
    rd(`OFS_CSHADOW + 8'h04, `RST_ZERO32, `RESP_OKAY);
    wr(`OFS_COMPARE + 8'h14, 32'(c), `RESP_OKAY);
    rd(`OFS_CSHADOW + 8'h14, `RST_ZERO32, `RESP_OKAY);
    wr(`OFS_RUN_CTL, 32'h00000007, `RESP_OKAY);
    gap(0, cycles_of(per + 1));
    gap(4, cycles_of(per + 1));
    gap(2, cycles_of(2 * per));
    gap(8, cycles_of(2 * per));
    gap(9, cycles_of(per + 1));
    gap(14, cycles_of(2 * per));
    gap(20, cycles_of(2 * per));
    // A longer immediate period takes over at once; counting runs on up to it
    wr(`OFS_PERIOD, 32'(per + 4), `RESP_OKAY);
    gap(0, cycles_of(per + 5));
    rd(`OFS_PSHADOW + 8'h04, 32'(per), `RESP_OKAY);
    rd(`OFS_CSHADOW + 8'h04, 32'(c), `RESP_OKAY);
    rd(`OFS_CSHADOW + 8'h14, 32'(c), `RESP_OKAY);
    report_and_stop();
  end
endmodule
`default_nettype wire
